//--- sim/auth_key_store_allocation_tb.sv
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module auth_key_store_allocation_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock, i_nrst, i_avs_read, i_avs_write, o_avs_waitrequest, o_busy;
  logic [7:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, rd, m_alloc, m_fresp, m_sess, m_presp;
  logic m_start, m_corrupt, m_reply, m_unconf;
  logic [3:0] m_src, m_new;
  logic [7:0] m_algo;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  auth_key_store u_auth_key_store (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_busy(o_busy));
  fixed_side_model u_fixed_side_model (.i_clock(i_clock), .i_nrst(i_nrst), .i_start(m_start),
    .i_corrupt(m_corrupt), .i_src_nr(m_src), .i_new_nr(m_new), .i_algo(m_algo),
    .i_seed(32'hA1B2C3D4), .i_portable_resp(m_presp), .o_alloc_word(m_alloc),
    .o_fixed_resp(m_fresp), .o_session(m_sess), .o_reply(m_reply), .o_unconfirmed(m_unconf));
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  task automatic stop_test();
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= wr;
    i_avs_read <= ~wr;
    @(posedge i_clock);
    while (o_avs_waitrequest !== 1'b0) @(posedge i_clock);
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  task automatic ctrl(input int b);
    bus(1'b1, key_store_pkg::OFF_CTRL, 32'h1 << b);
  endtask
  task automatic valid_half(input logic h);
    bus(1'b1, key_store_pkg::OFF_KEY_SEL, {23'h0, h, 8'h00});
    bus(1'b0, key_store_pkg::OFF_VALID, 32'h0);
  endtask
  task automatic load_key(input logic [3:0] kind, input logic [3:0] nr, input logic [31:0] k);
    bus(1'b1, key_store_pkg::OFF_KEY_SEL, {24'h0, kind, nr});
    bus(1'b1, key_store_pkg::OFF_KEY_DATA, k);
  endtask
  task automatic start_alloc(input logic [3:0] src, input logic [3:0] nw, input logic [7:0] al);
    ctrl(key_store_pkg::CTRL_ABORT);
    m_src <= src;
    m_new <= nw;
    m_algo <= al;
    m_start <= 1'b1;
    @(posedge i_clock);
    m_start <= 1'b0;
    @(posedge i_clock);
    bus(1'b1, key_store_pkg::OFF_ALLOC, m_alloc);
    ctrl(key_store_pkg::CTRL_GO);
  endtask
  task automatic t_reset();
    `CHK("waitreq", 1'b1, o_avs_waitrequest)
    bus(1'b0, key_store_pkg::OFF_STATUS, 32'h0);
    `CHK("status", 32'h0, rd)
    `CHK("busy", 1'b0, o_busy)
    bus(1'b0, 8'hFC, 32'h0);
    `CHK("unmapped", 32'h0, rd)
  endtask
  task automatic t_load();
    load_key(key_store_pkg::KIND_AUTH_CODE, 4'h3, 32'h0BADF00D);
    load_key(key_store_pkg::KIND_AUTH_CODE, 4'hB, 32'h12345678);
    load_key(key_store_pkg::KIND_SCK, 4'h2, 32'hCAFE0001);
    bus(1'b0, key_store_pkg::OFF_KEY_DATA, 32'h0);
    `CHK("key_data", 32'h0, rd)
    valid_half(1'b0);
    `CHK("valid0", 32'h08080000, rd)
    valid_half(1'b1);
    `CHK("valid1", 32'h00040000, rd)
  endtask
  task automatic t_reject();
    logic [7:0] al [3] = '{8'h00, 8'h02, 8'h01};
    logic [7:0] cd [3] = '{key_store_pkg::REJ_NO_ALGO, key_store_pkg::REJ_ALGO_UNSUP,
      key_store_pkg::REJ_KEY_ABSENT};
    for (int i = 0; i < 3; i++) begin
      start_alloc(4'h5, 4'h6, al[i]);
      bus(1'b0, key_store_pkg::OFF_STATUS, 32'h0);
      `CHK("rej_status", 32'h3, rd)
      bus(1'b0, key_store_pkg::OFF_REJECT, 32'h0);
      `CHK("rej_code", {24'h0, cd[i]}, rd)
    end
  endtask
  task automatic t_stray();
    ctrl(key_store_pkg::CTRL_ABORT);
    ctrl(key_store_pkg::CTRL_REPLY);
    bus(1'b0, key_store_pkg::OFF_STATUS, 32'h0);
    `CHK("stray_status", 32'h0, rd)
    valid_half(1'b0);
    `CHK("stray_valid", 32'h08080000, rd)
  endtask
  task automatic t_alloc(input logic bad);
    m_corrupt <= bad;
    start_alloc(4'h3, 4'h6, key_store_pkg::ALGO_SUPPORTED);
    bus(1'b0, key_store_pkg::OFF_STATUS, 32'h0);
    `CHK("wait_status", 32'h1, rd)
    `CHK("busy_wait", 1'b1, o_busy)
    m_presp <= 32'hA1B2C3D4 ^ 32'h3C3CA5A5;
    repeat (2) @(posedge i_clock);
    `CHK("fixed_reply", 1'b1, m_reply)
    bus(1'b1, key_store_pkg::OFF_RESP_CALC, 32'hA1B2C3D4 + 32'h11110000);
    bus(1'b1, key_store_pkg::OFF_RESP_IN, m_fresp);
    bus(1'b1, key_store_pkg::OFF_SESSION, m_sess);
    ctrl(key_store_pkg::CTRL_REPLY);
    bus(1'b0, key_store_pkg::OFF_STATUS, 32'h0);
    `CHK("end_status", bad ? 32'h3 : 32'h2, rd)
    `CHK("busy_end", 1'b0, o_busy)
    valid_half(1'b0);
    `CHK("user_key_valid", bad ? 32'h08080000 : 32'h08000040, rd)
    m_presp <= 32'h0;
  endtask
  task automatic t_derived(input logic flag, input logic [3:0] nr, input logic [31:0] ex);
    bus(1'b1, key_store_pkg::OFF_AUTH_TYPE, {16'h0, nr, 3'h0, flag, 8'h00});
    bus(1'b1, key_store_pkg::OFF_SESSION, 32'h5EED0000 + nr);
    ctrl(key_store_pkg::CTRL_AUTH_DONE);
    valid_half(1'b1);
    `CHK("derived_valid", ex, rd)
  endtask
  initial begin
    i_nrst = 1'b0;
    {i_avs_read, i_avs_write, m_start, m_corrupt} = 4'h0;
    {i_avs_address, m_src, m_new, m_algo} = 24'h0;
    {i_avs_writedata, m_presp} = 64'h0;
    repeat (16) @(posedge i_clock);
    i_nrst <= 1'b1;
    t_reset();
    t_load();
    t_reject();
    t_stray();
    t_alloc(1'b1);
    t_alloc(1'b0);
    `CHK("unconfirmed", 1'b1, m_unconf)
    t_derived(1'b1, 4'h1, 32'h00040002);
    t_derived(1'b0, 4'h4, 32'h00040002);
    t_derived(1'b1, 4'h1, 32'h00040002);
    t_derived(1'b1, 4'h9, 32'h00040202);
    stop_test();
  end
endmodule // auth_key_store_allocation_tb
`default_nettype wire

//--- sim/fixed_side_model.sv
`default_nettype none
module fixed_side_model (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic i_corrupt,
  input wire logic [3:0] i_src_nr,
  input wire logic [3:0] i_new_nr,
  input wire logic [7:0] i_algo,
  input wire logic [31:0] i_seed,
  input wire logic [31:0] i_portable_resp,
  output logic [31:0] o_alloc_word,
  output logic [31:0] o_fixed_resp,
  output logic [31:0] o_session,
  output logic o_reply,
  output logic o_unconfirmed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] seed_reg;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_alloc_word <= 32'h0;
      seed_reg <= 32'h0;
    end else if (i_start) begin
      o_alloc_word <= {key_store_pkg::MSG_KEY_ALLOCATE, i_algo, 8'h00, i_new_nr, i_src_nr};
      seed_reg <= i_seed;
    end
  end
  // reply only on match, key kept unconfirmed
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reply <= 1'b0;
      o_unconfirmed <= 1'b0;
    end else if (i_start) begin
      o_reply <= 1'b0;
    end else if (i_portable_resp == (seed_reg ^ 32'h3C3CA5A5)) begin
      o_reply <= 1'b1;
      o_unconfirmed <= 1'b1;
    end
  end
  // response from the echoed seed; corruption only on command
  assign o_fixed_resp = i_corrupt ? ~(seed_reg + 32'h11110000) : seed_reg + 32'h11110000;
  assign o_session = {seed_reg[15:0], seed_reg[31:16]};
endmodule // fixed_side_model
`default_nettype wire

//--- verilog/auth_key_store.sv
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`default_nettype none
// How it works
// - Three authentication key kinds and two cipher key kinds are recognised.
// - Per identity and per identity pair, up to 8 user keys and 8 codes.
// - The personal identity is never stored; software supplies it per use.
// - Authentication type carries a 4 bit key kind and a 4 bit slot number.
// - Top bit of the key number picks identity-only or identity-pair set.
// - For user key with personal identity, the number indexes the user key.
// - Allocation element holds 4 bit source code number and 4 bit new slot.
// - Cipher info holds 4 bit key kind and 4 bit number, top bit picks set.
// - Up to 8 static and 8 derived cipher keys per identity or pair.
// - All keys sit in one retained array; codes and static keys load manually.
// - Writing a derived cipher key overwrites the slot without any check.
// - Allocation accepted only for a supported algorithm and a held code.
// - Unacceptable allocation gives a reject with reason 11, 12 or 13.
// - Acceptable allocation gives a request naming algorithm, code kind, number.
// - Matching fixed response stores the session key and erases the code.
// - User key byte i is session key byte i modulo the session key length.
// - Source codes should be at least 32 bits long.
module auth_key_store #(
  parameter int KEY_W = 32,
  parameter int SLOTS = 8
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_busy
);
  if (KEY_W != 32 || SLOTS != 8) begin : g_param_check
    $error("auth_key_store: KEY_W 32 and SLOTS 8 only");
  end

  // --------------------------------
  // Storage: kind(0..3) x set(0..1) x slot(0..7)
  // --------------------------------
  // separate ranges
  logic [KEY_W-1:0] key_mem [0:63];
  logic [63:0] valid_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] alloc_reg;
  logic [31:0] auth_type_reg;
  logic [31:0] resp_in_reg;
  logic [31:0] session_reg;
  logic [31:0] key_sel_reg;
  logic [7:0] reject_reg;
  logic [31:0] resp_calc_reg;
  logic ack_reg;
  key_store_pkg::alloc_state_t state_reg;

  function automatic logic [5:0] slot_index(input logic [3:0] kind, input logic [3:0] num);
    logic [1:0] k;
    k = 2'h0;
    case (kind)
      key_store_pkg::KIND_USER_KEY: k = 2'h0;
      key_store_pkg::KIND_USER_KEY_PID: k = 2'h0;
      key_store_pkg::KIND_AUTH_CODE: k = 2'h1;
      key_store_pkg::KIND_DERIVED_KEY: k = 2'h2;
      default: k = 2'h3;
    endcase
    return {k, num[3], num[2:0]};
  endfunction

  logic wr_hit;
  logic rd_hit;
  logic [3:0] src_num;
  logic [3:0] new_num;
  logic [7:0] algo;
  logic [7:0] msg_type;
  logic [5:0] src_idx;
  logic [5:0] dst_idx;
  logic [5:0] derived_idx;
  logic [5:0] sel_idx;
  logic [31:0] user_key_value;
  logic accept;
  logic reply_ok;
  // Writes land at the edge where waitrequest is seen low
  assign wr_hit = i_avs_write && ack_reg;
  assign rd_hit = i_avs_read && !ack_reg;
  assign src_num = alloc_reg[key_store_pkg::FLD_NUM_LSB +: 4];
  assign new_num = alloc_reg[key_store_pkg::FLD_KIND_LSB +: 4];
  assign algo = alloc_reg[key_store_pkg::FLD_ALGO_LSB +: 8];
  assign msg_type = alloc_reg[key_store_pkg::FLD_MSG_LSB +: 8];
  assign src_idx = slot_index(key_store_pkg::KIND_AUTH_CODE, src_num);
  assign dst_idx = slot_index(key_store_pkg::KIND_USER_KEY, new_num);
  assign derived_idx = slot_index(key_store_pkg::KIND_DERIVED_KEY,
    auth_type_reg[key_store_pkg::FLD_DERIVED_NUM_LSB +: 4]);
  assign sel_idx = slot_index(key_sel_reg[7:4], key_sel_reg[3:0]);
  // one 32 bit session word repeats over the key
  assign user_key_value = session_reg;
  assign accept = (algo == key_store_pkg::ALGO_SUPPORTED) && valid_reg[src_idx];
  assign reply_ok = resp_in_reg == resp_calc_reg;

  // --------------------------------
  // Avalon slave: one wait cycle then ack
  // --------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (i_avs_read || i_avs_write) && !ack_reg;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !ack_reg);
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_avs_readdata <= 32'h00000000;
    end else if (rd_hit) begin
      case (i_avs_address)
        key_store_pkg::OFF_CTRL: o_avs_readdata <= ctrl_reg;
        key_store_pkg::OFF_STATUS: o_avs_readdata <= {30'h00000000, state_reg};
        key_store_pkg::OFF_ALLOC: o_avs_readdata <= alloc_reg;
        key_store_pkg::OFF_AUTH_TYPE: o_avs_readdata <= auth_type_reg;
        key_store_pkg::OFF_RESP_IN: o_avs_readdata <= resp_in_reg;
        key_store_pkg::OFF_RESP_CALC: o_avs_readdata <= resp_calc_reg;
        key_store_pkg::OFF_SESSION: o_avs_readdata <= session_reg;
        key_store_pkg::OFF_KEY_SEL: o_avs_readdata <= key_sel_reg;
        // Codes are write-only: a stored key never leaves the block
        key_store_pkg::OFF_KEY_DATA: o_avs_readdata <= 32'h00000000;
        key_store_pkg::OFF_VALID: o_avs_readdata <= key_sel_reg[8] ?
          valid_reg[63:32] : valid_reg[31:0];
        key_store_pkg::OFF_REJECT: o_avs_readdata <= {24'h000000, reject_reg};
        default: o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // --------------------------------
  // Software registers
  // --------------------------------
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      alloc_reg <= 32'h00000000;
      auth_type_reg <= 32'h00000000;
      resp_in_reg <= 32'h00000000;
      resp_calc_reg <= 32'h00000000;
      session_reg <= 32'h00000000;
      key_sel_reg <= 32'h00000000;
    end else if (wr_hit) begin
      case (i_avs_address)
        key_store_pkg::OFF_ALLOC: alloc_reg <= i_avs_writedata;
        key_store_pkg::OFF_AUTH_TYPE: auth_type_reg <= i_avs_writedata;
        key_store_pkg::OFF_RESP_IN: resp_in_reg <= i_avs_writedata;
        key_store_pkg::OFF_RESP_CALC: resp_calc_reg <= i_avs_writedata;
        key_store_pkg::OFF_SESSION: session_reg <= i_avs_writedata;
        key_store_pkg::OFF_KEY_SEL: key_sel_reg <= i_avs_writedata;
        default: ;
      endcase
    end
  end

  // Control pulses: self clearing after one cycle
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_reg <= 32'h00000000;
    end else if (wr_hit && i_avs_address == key_store_pkg::OFF_CTRL) begin
      ctrl_reg <= i_avs_writedata;
    end else begin
      ctrl_reg <= 32'h00000000;
    end
  end

  // --------------------------------
  // Allocation handshake
  // --------------------------------
  // idle after reset
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= key_store_pkg::ALLOC_IDLE;
      reject_reg <= 8'h00;
    end else if (ctrl_reg[key_store_pkg::CTRL_ABORT]) begin
      state_reg <= key_store_pkg::ALLOC_IDLE;
    end else begin
      case (state_reg)
        key_store_pkg::ALLOC_WAIT_REPLY: begin
          if (ctrl_reg[key_store_pkg::CTRL_REPLY]) begin
            state_reg <= reply_ok ? key_store_pkg::ALLOC_DONE : key_store_pkg::ALLOC_FAIL;
          end
        end
        default: begin
          if (ctrl_reg[key_store_pkg::CTRL_GO] && msg_type == key_store_pkg::MSG_KEY_ALLOCATE) begin
            if (accept) begin
              state_reg <= key_store_pkg::ALLOC_WAIT_REPLY;
              reject_reg <= 8'h00;
            end else begin
              state_reg <= key_store_pkg::ALLOC_FAIL;
              reject_reg <= (algo == 8'h00) ? key_store_pkg::REJ_NO_ALGO :
                (algo != key_store_pkg::ALGO_SUPPORTED) ? key_store_pkg::REJ_ALGO_UNSUP :
                key_store_pkg::REJ_KEY_ABSENT;
            end
          end
        end
      endcase
    end
  end

  logic commit;
  logic derived_store;
  assign commit = state_reg == key_store_pkg::ALLOC_WAIT_REPLY &&
    ctrl_reg[key_store_pkg::CTRL_REPLY] && reply_ok;
  assign derived_store = ctrl_reg[key_store_pkg::CTRL_AUTH_DONE] &&
    auth_type_reg[key_store_pkg::FLD_STORE_BIT];

  // --------------------------------
  // Key array and valid bits
  // --------------------------------
  // retained key store, manual load via KEY_DATA
  always_ff @(posedge i_clock) begin
    if (commit) begin
      key_mem[dst_idx] <= user_key_value;
    end else if (derived_store) begin
      key_mem[derived_idx] <= session_reg;
    end else if (wr_hit && i_avs_address == key_store_pkg::OFF_KEY_DATA) begin
      key_mem[sel_idx] <= i_avs_writedata;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      valid_reg <= 64'h0000000000000000;
    end else if (commit) begin
      // store new key, erase used code
      valid_reg[dst_idx] <= 1'b1;
      valid_reg[src_idx] <= 1'b0;
    end else if (derived_store) begin
      valid_reg[derived_idx] <= 1'b1;
    end else if (wr_hit && i_avs_address == key_store_pkg::OFF_KEY_DATA) begin
      valid_reg[sel_idx] <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= state_reg == key_store_pkg::ALLOC_WAIT_REPLY;
    end
  end

  // --------------------------------
  // Checks
  // --------------------------------
  // code erased after commit
  AST_CODE_ERASED: assert property (@(posedge i_clock) disable iff (!i_nrst)
    commit && src_idx != dst_idx |=> !valid_reg[$past(src_idx)])
    else $error("used code not erased");
  // reply while idle has no effect
  AST_IDLE_REPLY: assert property (@(posedge i_clock) disable iff (!i_nrst)
    state_reg == key_store_pkg::ALLOC_IDLE && !ctrl_reg[key_store_pkg::CTRL_GO]
    |=> state_reg == key_store_pkg::ALLOC_IDLE)
    else $error("handshake left idle without request");
  AST_ACCEPT: assert property (@(posedge i_clock) disable iff (!i_nrst)
    state_reg != key_store_pkg::ALLOC_WAIT_REPLY && ctrl_reg[key_store_pkg::CTRL_GO] &&
    msg_type == key_store_pkg::MSG_KEY_ALLOCATE && !accept && !ctrl_reg[key_store_pkg::CTRL_ABORT]
    |=> state_reg == key_store_pkg::ALLOC_FAIL && reject_reg != 8'h00)
    else $error("unacceptable allocation not rejected");
  AST_DERIVED_STORE: assert property (@(posedge i_clock) disable iff (!i_nrst)
    derived_store && !commit |=> valid_reg[$past(derived_idx)])
    else $error("derived key not stored");
  AST_REASON: assert property (@(posedge i_clock) disable iff (!i_nrst)
    reject_reg == 8'h00 || (reject_reg >= 8'h0B && reject_reg <= 8'h0D))
    else $error("reject reason out of range");
  // Bus reads answered within two cycles
  AST_BUS_ACK: assert property (@(posedge i_clock) disable iff (!i_nrst)
    $rose(i_avs_read) |-> ##[1:2] !o_avs_waitrequest)
    else $error("bus request not answered");
  AST_BUSY: assert property (@(posedge i_clock) disable iff (!i_nrst)
    state_reg == key_store_pkg::ALLOC_WAIT_REPLY |=> o_busy)
    else $error("busy missing during allocation");
  AST_SET_SPLIT: assert property (@(posedge i_clock) disable iff (!i_nrst)
    src_idx[3] == src_num[3])
    else $error("set bit lost in index");
endmodule // auth_key_store
`default_nettype wire

//--- verilog/key_store_pkg.sv
`default_nettype none
package key_store_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ALLOC = 8'h08;
  localparam logic [7:0] OFF_AUTH_TYPE = 8'h0C;
  localparam logic [7:0] OFF_RESP_IN = 8'h10;
  localparam logic [7:0] OFF_RESP_CALC = 8'h14;
  localparam logic [7:0] OFF_SESSION = 8'h18;
  localparam logic [7:0] OFF_KEY_SEL = 8'h1C;
  localparam logic [7:0] OFF_KEY_DATA = 8'h20;
  localparam logic [7:0] OFF_VALID = 8'h24;
  localparam logic [7:0] OFF_REJECT = 8'h28;
  // Key kinds in the 4 bit type field
  localparam logic [3:0] KIND_USER_KEY = 4'h1;
  localparam logic [3:0] KIND_AUTH_CODE = 4'h2;
  localparam logic [3:0] KIND_USER_KEY_PID = 4'h3;
  localparam logic [3:0] KIND_DERIVED_KEY = 4'h4;
  localparam logic [3:0] KIND_SCK = 4'h5;
  // Message type of the allocation request
  localparam logic [7:0] MSG_KEY_ALLOCATE = 8'h42;
  // Reject reasons
  localparam logic [7:0] REJ_NO_ALGO = 8'h0B;
  localparam logic [7:0] REJ_ALGO_UNSUP = 8'h0C;
  localparam logic [7:0] REJ_KEY_ABSENT = 8'h0D;
  // Field positions
  localparam int FLD_NUM_LSB = 0;
  localparam int FLD_KIND_LSB = 4;
  localparam int FLD_STORE_BIT = 8;
  localparam int FLD_ALGO_LSB = 16;
  localparam int FLD_DERIVED_NUM_LSB = 12;
  localparam int FLD_MSG_LSB = 24;
  // Control bits
  localparam int CTRL_GO = 0;
  localparam int CTRL_REPLY = 1;
  localparam int CTRL_AUTH_DONE = 2;
  localparam int CTRL_ABORT = 3;
  localparam logic [7:0] ALGO_SUPPORTED = 8'h01;
  localparam logic [1:0] ST_RESET = 2'h0;
  typedef enum logic [1:0] {
    ALLOC_IDLE = 2'b00,
    ALLOC_WAIT_REPLY = 2'b01,
    ALLOC_DONE = 2'b10,
    ALLOC_FAIL = 2'b11
  } alloc_state_t;
endpackage
`default_nettype wire
